// ===== verilog/tcu_regs.svh
// Register map, field positions and codes of the timer counter unit.
// Assumes inclusion by bare name from the design files.
`ifndef TCU_REGS_SVH
`define TCU_REGS_SVH
`define TCU_OFS_CTRL_A 8'h00
`define TCU_OFS_CTRL_B 8'h04
`define TCU_OFS_COUNT 8'h08
`define TCU_OFS_CMP_A 8'h0C
`define TCU_OFS_CMP_B 8'h10
`define TCU_OFS_MASK 8'h14
`define TCU_OFS_FLAG 8'h18
`define TCU_OFS_POWER 8'h1C
`define TCU_BOTTOM 8'h00
`define TCU_MAX 8'hFF
`define TCU_RST_BYTE 8'h00
`define TCU_FLAG_OVF 0
`define TCU_FLAG_CMPA 1
`define TCU_FLAG_CMPB 2
`define TCU_WGM2_BIT 3
`define TCU_PWR_BIT 0
`define TCU_CS_STOP 3'h0
`define TCU_CS_CLK1 3'h1
`define TCU_CS_DIV8 3'h2
`define TCU_CS_DIV64 3'h3
`define TCU_CS_DIV256 3'h4
`define TCU_CS_DIV1024 3'h5
`define TCU_CS_EXT_FALL 3'h6
`define TCU_CS_EXT_RISE 3'h7
`define TCU_MASK_DIV8 10'h007
`define TCU_MASK_DIV64 10'h03F
`define TCU_MASK_DIV256 10'h0FF
`define TCU_MASK_DIV1024 10'h3FF
`define TCU_WGM_NORMAL 3'h0
`define TCU_WGM_PC_MAX 3'h1
`define TCU_WGM_CTC 3'h2
`define TCU_WGM_FAST_MAX 3'h3
`define TCU_WGM_PC_CMPA 3'h5
`define TCU_WGM_FAST_CMPA 3'h7
`endif

// ===== verilog/tcu_pkg.sv
// Types shared by the timer counter unit modules.
// Assumes nothing beyond a SystemVerilog compiler.
package tcu_pkg;
  // Count sequence kinds decoded from the waveform mode field.
  typedef enum logic [1:0] {WAVE_NORMAL, WAVE_CLEAR, WAVE_FAST, WAVE_PHASE} tcu_wave_t;
  // Whole state of the counter unit top.
  typedef struct packed {
    logic [1:0] waveform_mode_low;
    logic waveform_mode_bit2;
    logic [2:0] clock_source_select;
    logic [7:0] counter_value;
    logic count_down;
    logic [2:0] timer_mask_reg;
    logic [2:0] timer_flag_reg;
    logic timer_power_off;
    logic block;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] irq;
    logic at_bottom;
    logic at_max;
    logic at_top;
  } tcu_state_t;
endpackage

// ===== verilog/tcu_cmp_if.sv
// Link between the counter unit and one compare register.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface tcu_cmp_if;
  logic buffered; // High when the mode uses double buffering.
  logic update; // Pulse that moves the buffer into the active value.
  logic wr; // Pulse that writes a new compare value.
  logic [7:0] wdata; // Value written by software.
  logic [7:0] active; // Value used by the comparator.
  logic [7:0] buffer; // Value software reads back.
  modport ctl(output buffered, update, wr, wdata, input active, buffer);
  modport cmp(input buffered, update, wr, wdata, output active, buffer);
endinterface
`default_nettype wire

// ===== verilog/tcu_compare_reg.sv
// Double-buffered compare value register.
// Assumes write and update pulses last one pclk cycle.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"
module tcu_compare_reg
  import tcu_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  tcu_cmp_if.cmp bus // Link to the counter unit.
);
  // State of one compare register.
  typedef struct packed {
    logic [7:0] active;
    logic [7:0] buffer;
  } tcu_cmp_state_t;
  tcu_cmp_state_t s; // Registered state.
  tcu_cmp_state_t next_s; // Next state.

  // A write lands in the buffer; it reaches the comparator at once only
  // when buffering is off, otherwise at the next update point.
  always_comb begin
    next_s = s;
    if (bus.wr) begin
      next_s.buffer = bus.wdata;
      if (!bus.buffered) begin
        next_s.active = bus.wdata;
      end
    end
    if (bus.buffered && bus.update) begin
      next_s.active = next_s.buffer;
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{active: `TCU_RST_BYTE, buffer: `TCU_RST_BYTE};
    end else begin
      s <= next_s;
    end
  end

  assign bus.active = s.active;
  assign bus.buffer = s.buffer;
endmodule
`default_nettype wire

// ===== verilog/tcu_tick_gen.sv
// Clock-select logic: prescaler and external pin edge detector.
// Assumes the external pin is asynchronous to pclk.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"
module tcu_tick_gen
  import tcu_pkg::*;
(
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic [2:0] clock_source_select, // Source and edge choice.
  input wire logic timer_power_off, // Holds the timer disabled.
  input wire logic external_count_input, // Asynchronous count pin.
  output logic timer_tick // One-cycle tick pulse.
);
  // State of the tick generator.
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic [9:0] pre;
    logic tick;
  } tcu_tick_state_t;
  tcu_tick_state_t s; // Registered state.
  tcu_tick_state_t next_s; // Next state.

  // Chooses one tick source; only the second sync stage is read.
  always_comb begin
    next_s = s;
    next_s.sync1 = external_count_input;
    next_s.sync2 = s.sync1;
    next_s.last = s.sync2;
    next_s.pre = s.pre + 10'h001;
    case (clock_source_select)
      `TCU_CS_CLK1: next_s.tick = 1'b1;
      `TCU_CS_DIV8: next_s.tick = (s.pre & `TCU_MASK_DIV8) == `TCU_MASK_DIV8;
      `TCU_CS_DIV64: next_s.tick = (s.pre & `TCU_MASK_DIV64) == `TCU_MASK_DIV64;
      `TCU_CS_DIV256: next_s.tick = (s.pre & `TCU_MASK_DIV256) == `TCU_MASK_DIV256;
      `TCU_CS_DIV1024: next_s.tick = s.pre == `TCU_MASK_DIV1024;
      `TCU_CS_EXT_FALL: next_s.tick = s.last && !s.sync2;
      `TCU_CS_EXT_RISE: next_s.tick = s.sync2 && !s.last;
      default: next_s.tick = 1'b0;
    endcase
    if (timer_power_off) begin
      next_s.tick = 1'b0;
      next_s.pre = 10'h000;
    end
  end

  // Registers the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign timer_tick = s.tick;
endmodule
`default_nettype wire

// ===== verilog/tcu_counter_unit.sv
// Counter unit of an 8-bit timer with two compare registers, APB slave.
// Assumes an APB master on pclk and an asynchronous count pin.
//
// Functional notes
// - Counter and compare registers are 8 bits.
// - Bottom is indicated when counter becomes zero.
// - Max is indicated when counter becomes 255.
// - Top is 255 or compare A per mode.
// - Tick source and edge chosen by clock select.
// - Clock select zero stops all ticks.
// - CPU reads and writes counter at any time.
// - CPU counter write beats clear or count.
// - Each tick clears or steps counter by one.
// - Three-bit mode split across both control registers.
// - Overflow flag set where the mode defines.
// - Compare registers matched against counter, flags set.
// - Both compare registers are double buffered in the PWM modes.
// - Three flags, each with its own mask bit.
// - Mode zero counts up, wraps, overflows at zero.
// - Mode two clears counter on compare A match.
// - Compare flag set on tick after match.
// - Counter write blocks compares on next tick.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"
module tcu_counter_unit
  import tcu_pkg::*;
(
  input wire logic pclk, // System clock, 50 MHz.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped address.
  input wire logic external_count_input, // External count pin.
  output logic [2:0] timer_irq_req, // Masked flags: ovf, cmp A, cmp B.
  output logic counter_at_bottom, // Counter holds zero.
  output logic counter_at_max, // Counter holds 255.
  output logic counter_at_top // Counter holds the mode's top.
);
  tcu_state_t s; // Registered state.
  tcu_state_t next_s; // Next state.
  logic timer_tick; // Tick from the clock-select logic.
  tcu_wave_t wave; // Decoded count sequence.
  logic top_from_cmpa; // Top comes from compare A.
  logic [7:0] top; // Current top value.
  logic [2:0] mode; // Whole waveform mode field.
  logic apb_setup; // Setup phase of a transfer.
  logic apb_done; // Transfer completes at this edge.
  logic wr_any; // Write completes at this edge.
  logic wr_count; // Software writes the counter.
  logic [31:0] read_mux; // Read value for the addressed register.
  logic mapped; // Address hits a register.
  logic [2:0] flag_set; // Hardware flag events.
  logic [2:0] flag_clr; // Software write-one-to-clear.
  logic update_buf; // Moment that moves compare buffers into active values.
  logic [7:0] count_step; // Counter after the tick.
  logic [7:0] cmp_active [2]; // Active compare values.
  logic [7:0] cmp_buffer [2]; // Readable compare values.
  tcu_cmp_if cmp_bus[2] (); // Links to the compare registers.

  // Clock-select logic with prescaler and pin synchroniser.
  tcu_tick_gen u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .clock_source_select(s.clock_source_select),
    .timer_power_off(s.timer_power_off),
    .external_count_input(external_count_input),
    .timer_tick(timer_tick)
  );

  // One compare register per channel, written by its own offset.
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    tcu_compare_reg u_cmp (
      .pclk(pclk),
      .presetn(presetn),
      .bus(cmp_bus[i])
    );
    // Buffering is used in every PWM kind of mode.
    assign cmp_bus[i].buffered = (wave == WAVE_FAST) || (wave == WAVE_PHASE);
    assign cmp_bus[i].update = update_buf;
    assign cmp_bus[i].wr = wr_any &&
      (paddr == ((i == 0) ? `TCU_OFS_CMP_A : `TCU_OFS_CMP_B));
    assign cmp_bus[i].wdata = pwdata[7:0];
    assign cmp_active[i] = cmp_bus[i].active;
    assign cmp_buffer[i] = cmp_bus[i].buffer;
  end

  // Decodes the mode field into a sequence kind and a top source.
  always_comb begin
    mode = {s.waveform_mode_bit2, s.waveform_mode_low};
    top_from_cmpa = 1'b0;
    case (mode)
      `TCU_WGM_NORMAL: wave = WAVE_NORMAL;
      `TCU_WGM_CTC: begin
        wave = WAVE_CLEAR;
        top_from_cmpa = 1'b1;
      end
      `TCU_WGM_FAST_MAX: wave = WAVE_FAST;
      `TCU_WGM_PC_MAX: wave = WAVE_PHASE;
      `TCU_WGM_FAST_CMPA: begin
        wave = WAVE_FAST;
        top_from_cmpa = 1'b1;
      end
      `TCU_WGM_PC_CMPA: begin
        wave = WAVE_PHASE;
        top_from_cmpa = 1'b1;
      end
      default: wave = WAVE_NORMAL; // Reserved codes count as normal.
    endcase
    top = top_from_cmpa ? cmp_active[0] : `TCU_MAX;
  end

  // Decodes the APB access and builds the read value.
  always_comb begin
    apb_setup = psel && !penable;
    apb_done = psel && penable && s.pready;
    wr_any = apb_done && pwrite;
    wr_count = wr_any && (paddr == `TCU_OFS_COUNT);
    mapped = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      `TCU_OFS_CTRL_A: read_mux[1:0] = s.waveform_mode_low;
      `TCU_OFS_CTRL_B: read_mux[3:0] = {s.waveform_mode_bit2, s.clock_source_select};
      `TCU_OFS_COUNT: read_mux[7:0] = s.counter_value;
      `TCU_OFS_CMP_A: read_mux[7:0] = cmp_buffer[0];
      `TCU_OFS_CMP_B: read_mux[7:0] = cmp_buffer[1];
      `TCU_OFS_MASK: read_mux[2:0] = s.timer_mask_reg;
      `TCU_OFS_FLAG: read_mux[2:0] = s.timer_flag_reg;
      `TCU_OFS_POWER: read_mux[`TCU_PWR_BIT] = s.timer_power_off;
      default: mapped = 1'b0; // Unmapped reads zero with an error.
    endcase
  end

  // Next state: registers, counting, flags and status outputs.
  always_comb begin
    next_s = s;
    flag_set = 3'h0;
    update_buf = 1'b0;
    count_step = s.counter_value;
    // Ready rises one cycle after setup, so no transfer has a wait state.
    next_s.pready = apb_setup;
    if (apb_setup) begin
      next_s.prdata = read_mux;
      next_s.pslverr = !mapped;
    end
    // Counting happens only on a tick; otherwise the value holds.
    if (timer_tick) begin
      case (wave)
        WAVE_NORMAL: begin
          count_step = s.counter_value + 8'h01;
          flag_set[`TCU_FLAG_OVF] = s.counter_value == `TCU_MAX;
        end
        WAVE_CLEAR: begin
          if (s.counter_value == top) begin
            count_step = `TCU_BOTTOM;
          end else begin
            count_step = s.counter_value + 8'h01;
          end
          flag_set[`TCU_FLAG_OVF] = s.counter_value == `TCU_MAX;
        end
        WAVE_FAST: begin
          if (s.counter_value == top) begin
            count_step = `TCU_BOTTOM;
            update_buf = 1'b1;
          end else begin
            count_step = s.counter_value + 8'h01;
          end
          flag_set[`TCU_FLAG_OVF] = s.counter_value == top;
        end
        WAVE_PHASE: begin
          if (!s.count_down) begin
            if (s.counter_value == top) begin
              next_s.count_down = 1'b1;
              count_step = s.counter_value - 8'h01;
              update_buf = 1'b1;
            end else begin
              count_step = s.counter_value + 8'h01;
            end
          end else if (s.counter_value == `TCU_BOTTOM) begin
            next_s.count_down = 1'b0;
            count_step = s.counter_value + 8'h01;
            flag_set[`TCU_FLAG_OVF] = 1'b1;
          end else begin
            count_step = s.counter_value - 8'h01;
          end
        end
        default: count_step = s.counter_value;
      endcase
      // A match seen before this tick sets its flag now, unless blocked.
      if (!s.block) begin
        flag_set[`TCU_FLAG_CMPA] = s.counter_value == cmp_active[0];
        flag_set[`TCU_FLAG_CMPB] = s.counter_value == cmp_active[1];
      end
      next_s.block = 1'b0;
    end
    if (wave != WAVE_PHASE) begin
      next_s.count_down = 1'b0;
    end
    next_s.counter_value = count_step;
    // Software writes win over any count in the same cycle.
    if (wr_count) begin
      next_s.counter_value = pwdata[7:0];
      next_s.block = 1'b1;
    end
    if (wr_any) begin
      case (paddr)
        `TCU_OFS_CTRL_A: next_s.waveform_mode_low = pwdata[1:0];
        `TCU_OFS_CTRL_B: begin
          next_s.clock_source_select = pwdata[2:0];
          next_s.waveform_mode_bit2 = pwdata[`TCU_WGM2_BIT];
        end
        `TCU_OFS_MASK: next_s.timer_mask_reg = pwdata[2:0];
        `TCU_OFS_POWER: next_s.timer_power_off = pwdata[`TCU_PWR_BIT];
        default: next_s.timer_mask_reg = s.timer_mask_reg;
      endcase
    end
    // Flags clear by writing one; a same-cycle event keeps its flag.
    flag_clr = (wr_any && paddr == `TCU_OFS_FLAG) ? pwdata[2:0] : 3'h0;
    next_s.timer_flag_reg = (s.timer_flag_reg & ~flag_clr) | flag_set;
    next_s.irq = next_s.timer_flag_reg & next_s.timer_mask_reg;
    next_s.at_bottom = next_s.counter_value == `TCU_BOTTOM;
    next_s.at_max = next_s.counter_value == `TCU_MAX;
    next_s.at_top = next_s.counter_value == top;
  end

  // Registers the whole state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign timer_irq_req = s.irq;
  assign counter_at_bottom = s.at_bottom;
  assign counter_at_max = s.at_max;
  assign counter_at_top = s.at_top;

  // Checks on the counting and flag behaviour.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // A normal-mode tick at 255 that no write overrides.
  sequence seq_normal_wrap;
    wave == WAVE_NORMAL && timer_tick && !wr_count && s.counter_value == `TCU_MAX;
  endsequence
  // A clear-mode tick on a compare A match.
  sequence seq_ctc_match;
    wave == WAVE_CLEAR && timer_tick && !wr_count && s.counter_value == cmp_active[0];
  endsequence

  property p_stop_no_tick;
    s.clock_source_select == `TCU_CS_STOP |=> !timer_tick;
  endproperty
  a_stop_no_tick: assert property (p_stop_no_tick) else $error("tick while stopped");

  property p_write_wins;
    wr_count |=> s.counter_value == $past(pwdata[7:0]) && s.block;
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_hold;
    !timer_tick && !wr_count |=> $stable(s.counter_value);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without tick");

  property p_normal_wrap;
    seq_normal_wrap |=> s.counter_value == `TCU_BOTTOM && s.timer_flag_reg[`TCU_FLAG_OVF];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("normal wrap wrong");

  property p_ctc_clear;
    seq_ctc_match |=> s.counter_value == `TCU_BOTTOM ##1 1'b1;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("clear on match missed");

  property p_block;
    s.block && timer_tick && !s.timer_flag_reg[`TCU_FLAG_CMPA] |=> !s.timer_flag_reg[`TCU_FLAG_CMPA];
  endproperty
  a_block: assert property (p_block) else $error("blocked compare set flag");

  property p_cmp_flag;
    timer_tick && !s.block && s.counter_value == cmp_active[1] |=> s.timer_flag_reg[`TCU_FLAG_CMPB];
  endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag B missed");

  property p_step;
    wave == WAVE_NORMAL && timer_tick && !wr_count |=> s.counter_value == 8'($past(s.counter_value) + 8'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter step wrong");

  property p_power;
    s.timer_power_off ##1 s.timer_power_off |-> !timer_tick;
  endproperty
  a_power: assert property (p_power) else $error("tick while powered off");

  property p_irq;
    timer_irq_req[`TCU_FLAG_OVF] |-> s.timer_flag_reg[`TCU_FLAG_OVF] && s.timer_mask_reg[`TCU_FLAG_OVF];
  endproperty
  a_irq: assert property (p_irq) else $error("unmasked request wrong");

  // Status outputs line up with the counter in the same cycle, flags follow their events.
  property p_bottom;
    1'b1 |=> counter_at_bottom == (s.counter_value == `TCU_BOTTOM);
  endproperty
  a_bottom: assert property (p_bottom) else $error("bottom indication wrong");

  property p_max;
    1'b1 |=> counter_at_max == (s.counter_value == `TCU_MAX);
  endproperty
  a_max: assert property (p_max) else $error("max indication wrong");

  property p_cmp_a;
    timer_tick && !s.block && s.counter_value == cmp_active[0] |=> s.timer_flag_reg[`TCU_FLAG_CMPA];
  endproperty
  a_cmp_a: assert property (p_cmp_a) else $error("compare flag A missed");

  property p_buffered;
    (wave == WAVE_FAST || wave == WAVE_PHASE) && !update_buf |=> $stable(cmp_active[0]);
  endproperty
  a_buffered: assert property (p_buffered) else $error("buffered compare moved early");

  property p_fast_ovf;
    wave == WAVE_FAST && timer_tick && s.counter_value == top |=> s.timer_flag_reg[`TCU_FLAG_OVF];
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("fast overflow missed");

  property p_phase_down;
    wave == WAVE_PHASE && timer_tick && !wr_count && s.count_down && s.counter_value != `TCU_BOTTOM
      |=> s.counter_value == 8'($past(s.counter_value) - 8'h01);
  endproperty
  a_phase_down: assert property (p_phase_down) else $error("down step wrong");
endmodule
`default_nettype wire

// ===== test/tb_timer0_counter_unit.sv
// Self-checking testbench for the timer counter unit, driving its APB port and count pin.
// Assumes the design files are compiled first and tcu_regs.svh is on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "tcu_regs.svh"
module tb_timer0_counter_unit
  import tcu_pkg::*;
;
  logic pclk = 1'b0; // System clock, 50 MHz.
  logic presetn = 1'b0; // Reset, active low.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB enable.
  logic pwrite = 1'b0; // APB direction.
  logic [7:0] paddr = 8'h00; // APB address.
  logic [31:0] pwdata = 32'h00000000; // APB write data.
  logic [31:0] prdata; // APB read data.
  logic pready; // APB ready.
  logic pslverr; // APB error.
  logic ext_pin = 1'b0; // External count pin.
  logic [2:0] timer_irq_req; // Masked flags.
  logic counter_at_bottom; // Counter is zero.
  logic counter_at_max; // Counter is 255.
  logic counter_at_top; // Counter is at top.
  int num_errors = 0; // Mismatches seen.
  int comparisons = 0; // Comparisons made.

  // The clock toggles every half period of 10 ns.
  always #10 pclk = ~pclk;

  tcu_counter_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_count_input(ext_pin), .timer_irq_req(timer_irq_req),
    .counter_at_bottom(counter_at_bottom), .counter_at_max(counter_at_max),
    .counter_at_top(counter_at_top));

  // Compares a value with its expectation and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    if (n >= 20) begin
      num_errors++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write with the error response ignored.
  task automatic wr(input logic [7:0] addr, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, addr, wd, rd, err);
  endtask

  // Register read, masked, compared with the expectation.
  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] msk, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, addr, 32'h00000000, rd, err);
    chk(rd & msk, exp);
  endtask

  // Waits for a number of clock cycles.
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Gives a number of high pulses on the count pin, slow enough for the synchroniser.
  task automatic pulses(input int n);
    repeat (n) begin
      ext_pin <= 1'b1;
      idle(12);
      ext_pin <= 1'b0;
      idle(12);
    end
  endtask

  // Reset values, bottom indication and holding while stopped.
  task automatic t_reset_and_hold();
    chk({counter_at_bottom, counter_at_max}, 32'h00000002);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h00000000);
    rd_chk(`TCU_OFS_FLAG, 32'hFFFFFFFF, 32'h00000000);
    wr(`TCU_OFS_COUNT, 32'h0000005A);
    idle(50);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h0000005A);
    wr(`TCU_OFS_CTRL_B, 32'h00000008);
    rd_chk(`TCU_OFS_CTRL_B, 32'h0000000F, 32'h00000008);
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
  endtask

  // An unmapped address is refused with an error and reads zero.
  task automatic t_unmapped();
    logic [31:0] rd;
    logic err;
    apb(1'b0, 8'h20, 32'h00000000, rd, err);
    chk({31'h0, err}, 32'h00000001);
    chk(rd, 32'h00000000);
  endtask

  // Normal mode wraps from 255 to zero and sets the overflow flag.
  task automatic t_normal_wrap();
    int n;
    wr(`TCU_OFS_COUNT, 32'h000000FD);
    wr(`TCU_OFS_FLAG, 32'h00000007);
    wr(`TCU_OFS_MASK, 32'h00000001);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_CLK1});
    for (n = 0; n < 40 && counter_at_max !== 1'b1; n++) idle(1);
    chk({31'h0, counter_at_max}, 32'h00000001);
    for (n = 0; n < 40 && counter_at_bottom !== 1'b1; n++) idle(1);
    chk({31'h0, counter_at_bottom}, 32'h00000001);
    idle(2);
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
    rd_chk(`TCU_OFS_FLAG, 32'h00000001, 32'h00000001);
    chk({31'h0, timer_irq_req[0]}, 32'h00000001);
  endtask

  // A mode whose top is compare A keeps the counter at or below it and sets the given flags.
  task automatic t_clear_on_match(input logic [2:0] mode, input logic [31:0] flags_exp);
    int n;
    logic top_seen;
    logic max_seen;
    top_seen = 1'b0;
    max_seen = 1'b0;
    wr(`TCU_OFS_CTRL_A, {30'h0, mode[1:0]});
    wr(`TCU_OFS_CTRL_B, {28'h0, mode[2], `TCU_CS_STOP});
    wr(`TCU_OFS_COUNT, 32'h00000000);
    wr(`TCU_OFS_CMP_A, 32'h00000005);
    wr(`TCU_OFS_FLAG, 32'h00000007);
    wr(`TCU_OFS_CTRL_B, {28'h0, mode[2], `TCU_CS_CLK1});
    for (n = 0; n < 300; n++) begin
      idle(1);
      top_seen = top_seen | (counter_at_top === 1'b1);
      max_seen = max_seen | (counter_at_max === 1'b1);
    end
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
    chk({30'h0, top_seen, max_seen}, 32'h00000002);
    rd_chk(`TCU_OFS_FLAG, 32'h00000003, flags_exp);
    wr(`TCU_OFS_CTRL_A, 32'h00000000);
  endtask

  // A counter write blocks the next match; a later match sets the flag; masking.
  task automatic t_block_and_mask();
    wr(`TCU_OFS_CMP_B, 32'h00000010);
    wr(`TCU_OFS_COUNT, 32'h00000010);
    wr(`TCU_OFS_FLAG, 32'h00000007);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_CLK1});
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
    rd_chk(`TCU_OFS_FLAG, 32'h00000004, 32'h00000000);
    wr(`TCU_OFS_COUNT, 32'h0000000E);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_CLK1});
    idle(4);
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
    rd_chk(`TCU_OFS_FLAG, 32'h00000004, 32'h00000004);
    wr(`TCU_OFS_MASK, 32'h00000000);
    idle(2);
    chk({29'h0, timer_irq_req}, 32'h00000000);
    wr(`TCU_OFS_MASK, 32'h00000004);
    idle(2);
    chk({29'h0, timer_irq_req}, 32'h00000004);
    wr(`TCU_OFS_FLAG, 32'h00000004);
    rd_chk(`TCU_OFS_FLAG, 32'h00000004, 32'h00000000);
  endtask

  // Power-off holds the counter; pin edges count; a write takes with the 1024 prescaler selected; buffered read-back.
  task automatic t_sources();
    wr(`TCU_OFS_POWER, 32'h00000001);
    wr(`TCU_OFS_COUNT, 32'h00000033);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_CLK1});
    idle(30);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h00000033);
    wr(`TCU_OFS_POWER, 32'h00000000);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_EXT_RISE});
    wr(`TCU_OFS_COUNT, 32'h00000000);
    pulses(3);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h00000003);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_EXT_FALL});
    wr(`TCU_OFS_COUNT, 32'h00000000);
    pulses(2);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h00000002);
    wr(`TCU_OFS_CTRL_B, {29'h0, `TCU_CS_DIV1024});
    wr(`TCU_OFS_COUNT, 32'h00000040);
    rd_chk(`TCU_OFS_COUNT, 32'hFFFFFFFF, 32'h00000040);
    wr(`TCU_OFS_CTRL_B, 32'h00000000);
    wr(`TCU_OFS_CTRL_A, 32'h00000003);
    wr(`TCU_OFS_CMP_A, 32'h00000077);
    rd_chk(`TCU_OFS_CMP_A, 32'hFFFFFFFF, 32'h00000077);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence: reset for 10 cycles, then every scenario in turn.
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    t_reset_and_hold();
    t_unmapped();
    t_normal_wrap();
    t_clear_on_match(`TCU_WGM_CTC, 32'h00000002);
    t_clear_on_match(`TCU_WGM_PC_CMPA, 32'h00000003);
    t_clear_on_match(`TCU_WGM_FAST_CMPA, 32'h00000003);
    t_block_and_mask();
    t_sources();
    tally_and_finish();
  end

  // Watchdog well beyond the fewer than two thousand cycles the scenarios need.
  initial begin
    #200000;
    num_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
